/* File: logic/register_arith_unit_cfg.svh */
// constants for the register arithmetic unit and its microcode store
`ifndef REGISTER_ARITH_UNIT_CFG_SVH
`define REGISTER_ARITH_UNIT_CFG_SVH

`define REGISTER_ARITH_UNIT_DATA_W 16
`define REGISTER_ARITH_UNIT_BYTE_MSB 7
`define REGISTER_ARITH_UNIT_NUM_REGS 16
`define REGISTER_ARITH_UNIT_REG_SEL_W 4
`define REGISTER_ARITH_UNIT_STORE_DEPTH 1024
`define REGISTER_ARITH_UNIT_STORE_ADDR_W 10
`define REGISTER_ARITH_UNIT_WORD_W 56
`define REGISTER_ARITH_UNIT_FIELD_COUNT 13
`define REGISTER_ARITH_UNIT_CTRL_W 9

// microword field positions
`define REGISTER_ARITH_UNIT_F1_LSB 0
`define REGISTER_ARITH_UNIT_F2_LSB 4
`define REGISTER_ARITH_UNIT_F3_LSB 8
`define REGISTER_ARITH_UNIT_SRC_LSB 0
`define REGISTER_ARITH_UNIT_FN_LSB 3
`define REGISTER_ARITH_UNIT_DEST_LSB 6
`define REGISTER_ARITH_UNIT_CODE_W 3

// reset values
`define REGISTER_ARITH_UNIT_REG_RST 16'h0000
`define REGISTER_ARITH_UNIT_WORD_RST 56'h00000000000000
`define REGISTER_ARITH_UNIT_BIT_RST 1'b0

`endif

/* File: logic/register_arith_unit_pkg.sv */
// types for the register arithmetic unit
package register_arith_unit_pkg;

    typedef enum logic [2:0] {
        SRC_A_Q = 3'h0,
        SRC_A_B = 3'h1,
        SRC_Z_Q = 3'h2,
        SRC_Z_B = 3'h3,
        SRC_Z_A = 3'h4,
        SRC_D_A = 3'h5,
        SRC_D_Q = 3'h6,
        SRC_D_Z = 3'h7
    } src_sel_t;

    typedef enum logic [2:0] {
        FN_ADD = 3'h0,
        FN_SUBR = 3'h1,
        FN_SUBS = 3'h2,
        FN_OR = 3'h3,
        FN_AND = 3'h4,
        FN_NOTRS = 3'h5,
        FN_XOR = 3'h6,
        FN_XNOR = 3'h7
    } fn_sel_t;

    typedef enum logic [2:0] {
        DST_QREG = 3'h0,
        DST_NOP = 3'h1,
        DST_RAMA = 3'h2,
        DST_RAMF = 3'h3,
        DST_RAMQD = 3'h4,
        DST_RAMD = 3'h5,
        DST_RAMQU = 3'h6,
        DST_RAMU = 3'h7
    } dest_sel_t;

endpackage

/* File: logic/register_arith_unit_fn_if.sv */
// operand and function bundle between the unit control and its datapath
`timescale 1ns/1ps
`default_nettype none
interface register_arith_unit_fn_if;
    import register_arith_unit_pkg::*;
    logic [15:0] port_a;
    logic [15:0] port_b;
    logic [15:0] data_in;
    logic [15:0] q_val;
    src_sel_t src;
    fn_sel_t fn;
    logic carry_in;
    logic byte_mode;
    logic [15:0] f_out;
    logic carry_out;

    modport ctl (output port_a, port_b, data_in, q_val, src, fn, carry_in, byte_mode, input f_out, carry_out);
    modport unit (input port_a, port_b, data_in, q_val, src, fn, carry_in, byte_mode, output f_out, carry_out);
endinterface
`default_nettype wire

/* File: logic/register_arith_unit_operand_fn.sv */
// operand source selection and function stage of the register arithmetic unit
`timescale 1ns/1ps
`default_nettype none
module register_arith_unit_operand_fn
    import register_arith_unit_pkg::*;
(
    // operands, selects and result
    register_arith_unit_fn_if.unit fn_bus
);

    wire logic [15:0] r_op;
    wire logic [15:0] s_op;
    wire logic r_is_a;
    wire logic r_is_d;
    wire logic s_is_q;
    wire logic s_is_b;
    wire logic s_is_a;
    wire logic [15:0] r_inv;
    wire logic [15:0] s_inv;
    wire logic [15:0] add_l;
    wire logic [15:0] add_r;
    wire logic [16:0] sum16;
    wire logic [8:0] sum8;
    wire logic is_arith;
    logic [15:0] logic_res;

    ////////////////////////////////////////////////////////////////////////////
    // r port: data, a or zero; s port: q, b, a or zero
    assign r_is_a = (fn_bus.src == SRC_A_Q) || (fn_bus.src == SRC_A_B);
    assign r_is_d = (fn_bus.src == SRC_D_A) || (fn_bus.src == SRC_D_Q) || (fn_bus.src == SRC_D_Z);
    assign s_is_q = (fn_bus.src == SRC_A_Q) || (fn_bus.src == SRC_Z_Q) || (fn_bus.src == SRC_D_Q);
    assign s_is_b = (fn_bus.src == SRC_A_B) || (fn_bus.src == SRC_Z_B);
    assign s_is_a = (fn_bus.src == SRC_Z_A) || (fn_bus.src == SRC_D_A);
    // zero on one port lets the other pass straight through for loads
    assign r_op = r_is_a ? fn_bus.port_a : (r_is_d ? fn_bus.data_in : 16'h0000);
    assign s_op = s_is_q ? fn_bus.q_val : (s_is_b ? fn_bus.port_b : (s_is_a ? fn_bus.port_a : 16'h0000));

    ////////////////////////////////////////////////////////////////////////////
    // subtraction is add of the inverted operand plus carry in
    assign r_inv = ~r_op;
    assign s_inv = ~s_op;
    assign add_l = (fn_bus.fn == FN_SUBR) ? r_inv : r_op;
    assign add_r = (fn_bus.fn == FN_SUBS) ? s_inv : s_op;
    assign sum16 = {1'b0, add_l} + {1'b0, add_r} + {16'h0000, fn_bus.carry_in};
    assign sum8 = {1'b0, add_l[7:0]} + {1'b0, add_r[7:0]} + {8'h00, fn_bus.carry_in};
    assign is_arith = (fn_bus.fn == FN_ADD) || (fn_bus.fn == FN_SUBR) || (fn_bus.fn == FN_SUBS);

    always_comb
    begin
        case (fn_bus.fn)
            FN_OR: logic_res = r_op | s_op;
            FN_AND: logic_res = r_op & s_op;
            FN_NOTRS: logic_res = r_inv & s_op;
            FN_XOR: logic_res = r_op ^ s_op;
            FN_XNOR: logic_res = ~(r_op ^ s_op);
            default: logic_res = sum16[15:0];
        endcase
    end

    assign fn_bus.f_out = logic_res;
    // carry taken at bit 7 in byte mode, bit 15 otherwise
    assign fn_bus.carry_out = is_arith & (fn_bus.byte_mode ? sum8[8] : sum16[16]);

endmodule // register_arith_unit_operand_fn
`default_nettype wire

/* File: logic/register_arith_unit.sv */
// register arithmetic unit with its microcode store and field 3 control decode
//
// Overview of operation
// - a 1K by 56-bit microcode store holds the microwords, each split into 13 fields, one the 9-bit unit control.
// - the low three control bits pick the operand sources and the middle three the function.
// - the first operand is data, port A or zero; the second is Q, port B, port A or zero.
// - source codes 0..7 give A,Q / A,B / 0,Q / 0,B / 0,A / D,A / D,Q / D,0.
// - function codes 0..7 give R+S, S-R, R-S, OR, AND, (not R) and S, XOR, XNOR on the result.
// - the top three control bits choose register, Q, output and shifter-end handling of the result.
// - destination 0 loads Q from the result, leaves the registers alone and drives the result out.
// - the data operand is a 16-line parallel input, lines 0 to 15.
// - Q as operand serves multiply and divide; zero as operand passes the other operand through.
// - port A reads the field 1 register, port B the field 2 register, and all register writes go to B.
// - destination 1 loads nothing, 2 loads B and drives port A out, 3 loads B and drives the result.
// - codes 4 and 5 write the result shifted down into B (4 shifts Q down too), 6 and 7 shift up (6 shifts Q).
`timescale 1ns/1ps
`default_nettype none
`include "register_arith_unit_cfg.svh"
module register_arith_unit
    import register_arith_unit_pkg::*;
#(
    parameter int DATA_W = `REGISTER_ARITH_UNIT_DATA_W,
    parameter int STORE_DEPTH = `REGISTER_ARITH_UNIT_STORE_DEPTH
)
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // microcode store loading
    input wire logic store_wr_en,
    input wire logic [`REGISTER_ARITH_UNIT_STORE_ADDR_W-1:0] store_wr_addr,
    input wire logic [`REGISTER_ARITH_UNIT_WORD_W-1:0] store_wr_data,
    // microinstruction issue from the sequencer
    input wire logic step_valid,
    input wire logic [`REGISTER_ARITH_UNIT_STORE_ADDR_W-1:0] step_addr,
    // operand data and per-step controls
    input wire logic [DATA_W-1:0] data_operand_lines,
    input wire logic carry_in,
    input wire logic byte_mode,
    input wire logic reg_shift_in,
    input wire logic q_shift_in,
    // results
    output logic [DATA_W-1:0] unit_result_output,
    output logic carry_out,
    output logic result_zero,
    output logic reg_shift_out,
    output logic q_shift_out,
    output logic step_done
);

    ////////////////////////////////////////////////////////////////////////////
    // elaboration checks
    generate
        if (DATA_W != `REGISTER_ARITH_UNIT_DATA_W)
        begin : g_bad_width
            $error("register_arith_unit supports a 16-bit datapath only");
        end
        if (STORE_DEPTH != `REGISTER_ARITH_UNIT_STORE_DEPTH)
        begin : g_bad_depth
            $error("register_arith_unit microcode store must hold 1024 words");
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // microcode store and fetched word
    logic [`REGISTER_ARITH_UNIT_WORD_W-1:0] ucode_store [0:STORE_DEPTH-1];
    logic [`REGISTER_ARITH_UNIT_WORD_W-1:0] word_ff;
    logic exec_ff;
    logic [15:0] data_ff;
    logic cin_ff;
    logic byte_ff;
    logic reg_in_ff;
    logic q_in_ff;

    always_ff @(posedge clk)
    begin
        if (store_wr_en)
        begin
            ucode_store[store_wr_addr] <= store_wr_data;
        end
    end

    // operands travel with the word so that a step sees one consistent set
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            word_ff <= `REGISTER_ARITH_UNIT_WORD_RST;
            exec_ff <= `REGISTER_ARITH_UNIT_BIT_RST;
            data_ff <= `REGISTER_ARITH_UNIT_REG_RST;
            cin_ff <= `REGISTER_ARITH_UNIT_BIT_RST;
            byte_ff <= `REGISTER_ARITH_UNIT_BIT_RST;
            reg_in_ff <= `REGISTER_ARITH_UNIT_BIT_RST;
            q_in_ff <= `REGISTER_ARITH_UNIT_BIT_RST;
        end
        else
        begin
            word_ff <= ucode_store[step_addr];
            exec_ff <= step_valid;
            data_ff <= data_operand_lines;
            cin_ff <= carry_in;
            byte_ff <= byte_mode;
            reg_in_ff <= reg_shift_in;
            q_in_ff <= q_shift_in;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // field decode
    wire logic [`REGISTER_ARITH_UNIT_REG_SEL_W-1:0] a_sel;
    wire logic [`REGISTER_ARITH_UNIT_REG_SEL_W-1:0] b_sel;
    wire logic [`REGISTER_ARITH_UNIT_CTRL_W-1:0] ctrl_field;
    wire src_sel_t src_code;
    wire fn_sel_t fn_code;
    wire dest_sel_t dest_code;

    assign a_sel = word_ff[`REGISTER_ARITH_UNIT_F1_LSB +: `REGISTER_ARITH_UNIT_REG_SEL_W];
    assign b_sel = word_ff[`REGISTER_ARITH_UNIT_F2_LSB +: `REGISTER_ARITH_UNIT_REG_SEL_W];
    assign ctrl_field = word_ff[`REGISTER_ARITH_UNIT_F3_LSB +: `REGISTER_ARITH_UNIT_CTRL_W];
    assign src_code = src_sel_t'(ctrl_field[`REGISTER_ARITH_UNIT_SRC_LSB +: `REGISTER_ARITH_UNIT_CODE_W]);
    assign fn_code = fn_sel_t'(ctrl_field[`REGISTER_ARITH_UNIT_FN_LSB +: `REGISTER_ARITH_UNIT_CODE_W]);
    assign dest_code = dest_sel_t'(ctrl_field[`REGISTER_ARITH_UNIT_DEST_LSB +: `REGISTER_ARITH_UNIT_CODE_W]);

    ////////////////////////////////////////////////////////////////////////////
    // register file, q and the function stage
    logic [15:0] regs_ff [0:`REGISTER_ARITH_UNIT_NUM_REGS-1];
    logic [15:0] q_ff;
    wire logic [15:0] port_a;
    wire logic [15:0] port_b;
    wire logic [15:0] f_val;
    wire logic f_carry;

    assign port_a = regs_ff[a_sel];
    assign port_b = regs_ff[b_sel];

    register_arith_unit_fn_if fn_bus ();

    assign fn_bus.port_a = port_a;
    assign fn_bus.port_b = port_b;
    assign fn_bus.data_in = data_ff;
    assign fn_bus.q_val = q_ff;
    assign fn_bus.src = src_code;
    assign fn_bus.fn = fn_code;
    assign fn_bus.carry_in = cin_ff;
    assign fn_bus.byte_mode = byte_ff;
    assign f_val = fn_bus.f_out;
    assign f_carry = fn_bus.carry_out;

    register_arith_unit_operand_fn u_fn (
        .fn_bus(fn_bus.unit)
    );

    ////////////////////////////////////////////////////////////////////////////
    // destination decode and shifters
    wire logic shift_down;
    wire logic shift_up;
    wire logic reg_load;
    wire logic q_load_f;
    wire logic q_shift;
    wire logic [15:0] f_down;
    wire logic [15:0] f_up;
    wire logic [15:0] q_down;
    wire logic [15:0] q_up;
    wire logic [15:0] reg_next;
    wire logic [15:0] nxt_q;
    wire logic [15:0] out_next;
    wire logic f_msb;
    wire logic q_msb;
    wire logic nxt_reg_out;
    wire logic nxt_q_out;
    wire logic [15:0] zero_mask;

    assign shift_down = (dest_code == DST_RAMQD) || (dest_code == DST_RAMD);
    assign shift_up = (dest_code == DST_RAMQU) || (dest_code == DST_RAMU);
    assign reg_load = (dest_code != DST_QREG) && (dest_code != DST_NOP);
    assign q_load_f = (dest_code == DST_QREG);
    assign q_shift = (dest_code == DST_RAMQD) || (dest_code == DST_RAMQU);

    // in byte mode only the low byte shifts; the top byte passes untouched
    assign f_down = byte_ff ? {f_val[15:8], reg_in_ff, f_val[7:1]} : {reg_in_ff, f_val[15:1]};
    assign f_up = byte_ff ? {f_val[15:8], f_val[6:0], reg_in_ff} : {f_val[14:0], reg_in_ff};
    assign q_down = byte_ff ? {q_ff[15:8], q_in_ff, q_ff[7:1]} : {q_in_ff, q_ff[15:1]};
    assign q_up = byte_ff ? {q_ff[15:8], q_ff[6:0], q_in_ff} : {q_ff[14:0], q_in_ff};
    assign f_msb = byte_ff ? f_val[`REGISTER_ARITH_UNIT_BYTE_MSB] : f_val[15];
    assign q_msb = byte_ff ? q_ff[`REGISTER_ARITH_UNIT_BYTE_MSB] : q_ff[15];

    assign reg_next = shift_down ? f_down : (shift_up ? f_up : f_val);
    assign nxt_q = q_load_f ? f_val : (dest_code == DST_RAMQD ? q_down : q_up);
    assign out_next = (dest_code == DST_RAMA) ? port_a : f_val;
    // bit leaving the register shifter: lsb going down, msb going up
    assign nxt_reg_out = shift_down ? f_val[0] : (shift_up ? f_msb : 1'b0);
    assign nxt_q_out = (dest_code == DST_RAMQD) ? q_ff[0] : ((dest_code == DST_RAMQU) ? q_msb : 1'b0);
    assign zero_mask = byte_ff ? 16'h00ff : 16'hffff;

    ////////////////////////////////////////////////////////////////////////////
    // state update on the edge that ends the step
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            for (int i = 0; i < `REGISTER_ARITH_UNIT_NUM_REGS; i++)
            begin
                regs_ff[i] <= `REGISTER_ARITH_UNIT_REG_RST;
            end
        end
        else if (exec_ff && reg_load)
        begin
            regs_ff[b_sel] <= reg_next;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            q_ff <= `REGISTER_ARITH_UNIT_REG_RST;
        end
        else if (exec_ff && (q_load_f || q_shift))
        begin
            q_ff <= nxt_q;
        end
    end

    // outputs hold the last step's values between steps
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            unit_result_output <= `REGISTER_ARITH_UNIT_REG_RST;
            carry_out <= `REGISTER_ARITH_UNIT_BIT_RST;
            result_zero <= `REGISTER_ARITH_UNIT_BIT_RST;
            reg_shift_out <= `REGISTER_ARITH_UNIT_BIT_RST;
            q_shift_out <= `REGISTER_ARITH_UNIT_BIT_RST;
        end
        else if (exec_ff)
        begin
            unit_result_output <= out_next;
            carry_out <= f_carry;
            result_zero <= ((f_val & zero_mask) == 16'h0000);
            reg_shift_out <= nxt_reg_out;
            q_shift_out <= nxt_q_out;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            step_done <= `REGISTER_ARITH_UNIT_BIT_RST;
        end
        else
        begin
            step_done <= exec_ff;
        end
    end

endmodule // register_arith_unit
`default_nettype wire

/* File: verification/register_arith_unit_port_chk.sv */
// concurrent checks on the register arithmetic unit ports
`timescale 1ns/1ps
`default_nettype none
module register_arith_unit_port_chk
    import register_arith_unit_pkg::*;
#(
    parameter int DATA_W = 16
)
(
    // every port of the unit
    input wire logic clk,
    input wire logic rst,
    input wire logic store_wr_en,
    input wire logic [9:0] store_wr_addr,
    input wire logic [55:0] store_wr_data,
    input wire logic step_valid,
    input wire logic [9:0] step_addr,
    input wire logic [DATA_W-1:0] data_operand_lines,
    input wire logic carry_in,
    input wire logic byte_mode,
    input wire logic reg_shift_in,
    input wire logic q_shift_in,
    input wire logic [DATA_W-1:0] unit_result_output,
    input wire logic carry_out,
    input wire logic result_zero,
    input wire logic reg_shift_out,
    input wire logic q_shift_out,
    input wire logic step_done
);
    // shadow of the control field, so each check knows what its step asked for
    logic [8:0] ctl_ff [0:1023];
    logic [25:0] p1_ff;
    logic [25:0] p2_ff;
    always_ff @(posedge clk)
    begin
        if (store_wr_en)
        begin
            ctl_ff[store_wr_addr] <= store_wr_data[16:8];
        end
        p1_ff <= {ctl_ff[step_addr], byte_mode, data_operand_lines[15:0]};
        p2_ff <= p1_ff;
    end
    // results are sampled two edges after the issue edge, so two stages line up
    wire [2:0] src_w = p2_ff[19:17];
    wire [2:0] fn_w = p2_ff[22:20];
    wire [2:0] dst_w = p2_ff[25:23];
    wire [15:0] dat_w = p2_ff[15:0];
    wire word_w = step_done && !p2_ff[16];
    wire pass_w = word_w && src_w == 3'h7 && fn_w == 3'h3;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    step_lat_a: assert property (step_valid |-> ##2 step_done)
        else $error("no step_done two edges after a step");
    done_cause_a: assert property (step_done |-> $past(step_valid, 2))
        else $error("step_done without a step");
    out_hold_a: assert property (!step_done && !$past(rst) |-> $stable(unit_result_output) && $stable(carry_out))
        else $error("outputs moved without a step");
    pass_thru_a: assert property (pass_w && dst_w != 3'h2 |-> unit_result_output == dat_w)
        else $error("data with zero not passed through");
    zero_flag_a: assert property (word_w && dst_w != 3'h2 |-> result_zero == (unit_result_output == 16'h0000))
        else $error("zero flag disagrees with result");
    logic_carry_a: assert property (step_done && fn_w >= 3'h3 |-> !carry_out)
        else $error("carry set by a logic function");
    q_quiet_a: assert property (step_done && dst_w != 3'h4 && dst_w != 3'h6 |-> !q_shift_out)
        else $error("q shift out without a q shift");
    r_quiet_a: assert property (step_done && !dst_w[2] |-> !reg_shift_out)
        else $error("register shift out without a shift");
    r_edge_a: assert property (pass_w && dst_w[2] |-> reg_shift_out == (dst_w[1] ? dat_w[15] : dat_w[0]))
        else $error("wrong bit left the register shifter");
endmodule // register_arith_unit_port_chk

bind register_arith_unit register_arith_unit_port_chk #(.DATA_W(DATA_W)) u_chk (.clk(clk), .rst(rst),
    .store_wr_en(store_wr_en), .store_wr_addr(store_wr_addr), .store_wr_data(store_wr_data),
    .step_valid(step_valid), .step_addr(step_addr), .data_operand_lines(data_operand_lines),
    .carry_in(carry_in), .byte_mode(byte_mode), .reg_shift_in(reg_shift_in), .q_shift_in(q_shift_in),
    .unit_result_output(unit_result_output), .carry_out(carry_out), .result_zero(result_zero),
    .reg_shift_out(reg_shift_out), .q_shift_out(q_shift_out), .step_done(step_done));
`default_nettype wire

/* File: verification/register_arith_unit_seq_model.sv */
// microcode loader and step issuer standing in for the sequencer
`timescale 1ns/1ps
`default_nettype none
module register_arith_unit_seq_model
(
    // clock
    input wire logic clk,
    // store and step controls
    output var logic store_wr_en,
    output var logic [9:0] store_wr_addr,
    output var logic [55:0] store_wr_data,
    output var logic step_valid,
    output var logic [9:0] step_addr,
    // operands
    output var logic [15:0] data_operand_lines,
    output var logic carry_in,
    output var logic byte_mode,
    output var logic reg_shift_in,
    output var logic q_shift_in
);
    initial
    begin
        {store_wr_en, store_wr_addr, store_wr_data, step_valid, step_addr} = '0;
        {data_operand_lines, carry_in, byte_mode, reg_shift_in, q_shift_in} = '0;
    end
    // enable is left high; the next issue drops it
    task automatic load(input logic [9:0] a, input logic [8:0] ctl, input logic [3:0] fb, fa);
        store_wr_en = 1'b1;
        store_wr_addr = a;
        store_wr_data = {39'h0, ctl, fb, fa};
        @(posedge clk);
        #1;
    endtask
    // m is byte mode, carry in, register and q shift-in bits
    task automatic issue(input logic [9:0] a, input logic [15:0] x, input logic [3:0] m, input logic keep);
        store_wr_en = 1'b0;
        step_valid = 1'b1;
        step_addr = a;
        data_operand_lines = x;
        {byte_mode, carry_in, reg_shift_in, q_shift_in} = m;
        @(posedge clk);
        #1;
        if (!keep)
        begin
            step_valid = 1'b0;
            // released lines must not keep looking valid
            data_operand_lines = ~x;
        end
    endtask
endmodule // register_arith_unit_seq_model
`default_nettype wire

/* File: verification/register_arith_unit_tb.sv */
// self-checking bench for the register arithmetic unit
`timescale 1ns/1ps
`default_nettype none
module register_arith_unit_tb;
    import register_arith_unit_pkg::*;
    logic clk;
    logic rst;
    wire store_wr_en, step_valid, carry_in, byte_mode, reg_shift_in, q_shift_in;
    wire [9:0] store_wr_addr;
    wire [9:0] step_addr;
    wire [55:0] store_wr_data;
    wire [15:0] data_operand_lines;
    logic [15:0] unit_result_output;
    logic carry_out, result_zero, reg_shift_out, q_shift_out, step_done;
    int error_cnt = 0;
    int n_checks = 0;
    logic [9:0] wa = 10'h000;

    register_arith_unit uut (.clk(clk), .rst(rst), .store_wr_en(store_wr_en),
        .store_wr_addr(store_wr_addr), .store_wr_data(store_wr_data), .step_valid(step_valid),
        .step_addr(step_addr), .data_operand_lines(data_operand_lines), .carry_in(carry_in),
        .byte_mode(byte_mode), .reg_shift_in(reg_shift_in), .q_shift_in(q_shift_in),
        .unit_result_output(unit_result_output), .carry_out(carry_out), .result_zero(result_zero),
        .reg_shift_out(reg_shift_out), .q_shift_out(q_shift_out), .step_done(step_done));
    register_arith_unit_seq_model seq (.clk(clk), .store_wr_en(store_wr_en), .store_wr_addr(store_wr_addr),
        .store_wr_data(store_wr_data), .step_valid(step_valid), .step_addr(step_addr),
        .data_operand_lines(data_operand_lines), .carry_in(carry_in), .byte_mode(byte_mode),
        .reg_shift_in(reg_shift_in), .q_shift_in(q_shift_in));

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [15:0] g, e);
        n_checks++;
        if (g !== e)
        begin
            error_cnt++;
            $display("CHECK FAILED t=%0t got %h expected %h", $time, g, e);
        end
    endtask
    function automatic logic [16:0] alu(input logic [2:0] f, input logic [15:0] r, s, input logic c);
        case (f)
            3'h0: alu = {1'b0, r} + {1'b0, s} + {16'h0, c};
            3'h1: alu = {1'b0, s} + {1'b0, ~r} + {16'h0, c};
            3'h2: alu = {1'b0, r} + {1'b0, ~s} + {16'h0, c};
            3'h3: alu = {1'b0, r | s};
            3'h4: alu = {1'b0, r & s};
            3'h5: alu = {1'b0, ~r & s};
            3'h6: alu = {1'b0, r ^ s};
            default: alu = {1'b0, ~(r ^ s)};
        endcase
    endfunction
    function automatic logic [15:0] sh(input logic [15:0] v, input logic up, b, bm);
        sh = up ? {v[14:0], b} : {b, v[15:1]};
        if (bm)
            sh = {v[15:8], up ? {v[6:0], b} : {b, v[7:1]}};
    endfunction
    // one step from a fresh store word; returns once its results are out
    task automatic run(input logic [3:0] a, b, input logic [2:0] s, f, d, input logic [15:0] x,
        input logic [3:0] m);
        int n;
        n = 0;
        seq.load(wa, {d, f, s}, b, a);
        seq.issue(wa, x, m, 1'b0);
        wa = wa + 10'h1;
        while (step_done !== 1'b1 && n < 20)
        begin
            @(posedge clk);
            #1;
            n++;
        end
        if (n >= 20)
        begin
            error_cnt++;
            $display("CHECK FAILED t=%0t step never finished", $time);
        end
    endtask
    task automatic rd(input logic [3:0] a, input logic [2:0] s, input logic [15:0] e);
        run(a, 4'h0, s, FN_OR, DST_NOP, 16'h0000, 4'h0);
        chk(unit_result_output, e);
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        chk({11'h0, carry_out, result_zero, reg_shift_out, q_shift_out, step_done}, 16'h0000);
        rd(4'h1, SRC_Z_A, 16'h0000);
        rd(4'h0, SRC_Z_Q, 16'h0000);
        $display("test reset done");
    endtask
    task automatic t_fn();
        logic [16:0] e;
        run(4'h0, 4'h1, SRC_D_Z, FN_OR, DST_RAMF, 16'hf0f0, 4'h0);
        run(4'h0, 4'h2, SRC_D_Z, FN_OR, DST_RAMF, 16'h0f0f, 4'h0);
        for (int f = 0; f < 8; f++)
        begin
            e = alu(f[2:0], 16'hf0f0, 16'h0f0f, f == 1 || f == 2);
            run(4'h1, 4'h2, SRC_A_B, f[2:0], DST_NOP, 16'h0000, {1'b0, f == 1 || f == 2, 2'b00});
            chk(unit_result_output, e[15:0]);
            chk({carry_out, result_zero, 14'h0}, {e[16], e[15:0] == 16'h0000, 14'h0});
        end
        // byte mode: f0f0 + 0110 carries out of bit 7 and leaves a zero low byte
        run(4'h1, 4'h0, SRC_D_A, FN_ADD, DST_NOP, 16'h0110, 4'h8);
        chk(unit_result_output, 16'hf200);
        chk({carry_out, result_zero, 14'h0}, {2'b11, 14'h0});
        rd(4'h2, SRC_Z_A, 16'h0f0f);
        $display("test functions done");
    endtask
    task automatic t_src();
        logic [15:0] r;
        logic [15:0] s;
        run(4'h0, 4'h0, SRC_D_Z, FN_OR, DST_QREG, 16'h3c00, 4'h0);
        chk(unit_result_output, 16'h3c00);
        for (int k = 0; k < 8; k++)
        begin
            r = k > 4 ? 16'h0005 : (k < 2 ? 16'hf0f0 : 16'h0000);
            s = (k == 0 || k == 2 || k == 6) ? 16'h3c00 : (k == 7 ? 16'h0000 : (k > 3 ? 16'hf0f0 : 16'h0f0f));
            run(4'h1, 4'h2, k[2:0], FN_ADD, DST_NOP, 16'h0005, 4'h0);
            chk(unit_result_output, r + s);
        end
        $display("test sources done");
    endtask
    task automatic t_dst();
        logic [2:0] d;
        logic bm;
        run(4'h1, 4'h3, SRC_D_Z, FN_OR, DST_RAMA, 16'h5a5a, 4'h0);
        chk(unit_result_output, 16'hf0f0);
        rd(4'h3, SRC_Z_A, 16'h5a5a);
        // last pass repeats the down shift in byte mode
        for (int i = 0; i < 5; i++)
        begin
            d = i < 4 ? 3'(4 + i) : 3'h4;
            bm = i == 4;
            run(4'h0, 4'h0, SRC_D_Z, FN_OR, DST_QREG, 16'h8421, 4'h0);
            run(4'h0, 4'h4, SRC_D_Z, FN_OR, d, 16'hc3a6, {bm, 1'b0, i[0], ~i[0]});
            chk(unit_result_output, 16'hc3a6);
            chk({14'h0, reg_shift_out, q_shift_out}, {14'h0, d[1], ~d[0]});
            rd(4'h4, SRC_Z_A, sh(16'hc3a6, d[1], i[0], bm));
            rd(4'h0, SRC_Z_Q, d[0] ? 16'h8421 : sh(16'h8421, d[1], ~i[0], bm));
        end
        $display("test destinations done");
    endtask
    task automatic t_b2b();
        seq.load(wa, {DST_RAMF, FN_OR, SRC_D_Z}, 4'h5, 4'h0);
        seq.load(wa + 10'h1, {DST_NOP, FN_ADD, SRC_D_A}, 4'h0, 4'h5);
        seq.issue(wa, 16'h0c3c, 4'h0, 1'b1);
        seq.issue(wa + 10'h1, 16'h0001, 4'h0, 1'b0);
        wa = wa + 10'h2;
        @(posedge clk);
        #1;
        chk({step_done, 15'h0}, 16'h8000);
        @(posedge clk);
        #1;
        chk(unit_result_output, 16'h0c3d);
        $display("test back to back done");
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    initial
    begin
        #(8 * 5000);
        error_cnt++;
        complete_run();
    end
    initial
    begin
        rst = 1'b1;
        repeat (5) @(posedge clk);
        #1;
        rst = 1'b0;
        t_reset();
        t_fn();
        t_src();
        t_dst();
        t_b2b();
        complete_run();
    end
endmodule // register_arith_unit_tb
`default_nettype wire
